// ---- hw/rss_sequencer.sv ----
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module rss_sequencer #(
  parameter int MsCycles = rss_pkg::MS_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire rss_pkg::rss_ahb_req_t ahbReq,
  input wire logic hready,
  output var rss_pkg::rss_ahb_rsp_t ahbRsp,
  input wire logic enablePin,
  input wire logic [1:0] generalPurposeInput,
  output var logic [3:0] masterOutputOn
);
  //==============================================================
  // State
  typedef struct packed {
    // Software registers
    logic [7:0] ctrl;
    logic [7:0] upA;
    logic [7:0] upB;
    logic [7:0] upC;
    logic [7:0] dnA;
    logic [7:0] dnB;
    logic [7:0] gpiFunc;
    // Bus pipeline
    logic wrPend;
    logic [5:0] wIdx;
    logic [31:0] rdata;
    // Pin synchronisers
    logic [1:0] enSync;
    logic [1:0] gpiS0;
    logic [1:0] gpiS1;
    // Delay engines
    logic [3:0] seqOn;
    logic [3:0] pend;
    logic [3:0] dir;
    logic [3:0][15:0] cyc;
    logic [3:0][5:0] msLeft;
    // Registered outputs
    logic [3:0] outOn;
  } rss_state_t;

  rss_state_t stateQ, stateD;

  //==============================================================
  // Decode helpers

  // Bit 0 global turn-on, bits 1..4 masters 1..4; other codes ignored
  function automatic logic [4:0] gpi_route(input logic [3:0] func, input logic lvl);
    logic [4:0] r;
    r = 5'h00;
    if (func <= rss_pkg::FUNC_LAST_MASTER) begin
      r[func[2:0]] = lvl;
    end
    return r;
  endfunction : gpi_route

  // Whole ms to wait: the code, or the code doubled for the long unit
  function automatic logic [5:0] wait_ms(input logic [4:0] code, input logic longUnit);
    logic [5:0] w;
    w = {1'b0, code};
    if (longUnit) begin // [RULE1]
      w = {code, 1'b0}; // [RULE2]
    end
    return w;
  endfunction : wait_ms

  //==============================================================
  // Combinational helpers
  logic [4:0] route;
  logic globalReq;
  logic [3:0][4:0] upCode;
  logic [3:0][4:0] dnCode;
  logic take;
  // Per-master engine conditions
  logic [3:0] freshEdge;
  logic [3:0] backOff;
  logic [3:0] expired;
  logic [3:0] msTick;
  logic [3:0][5:0] loadMs;

  //==============================================================
  // Next state
  always_comb begin
    stateD = stateQ;
    // Pins pass two flops before use
    stateD.enSync = {stateQ.enSync[0], enablePin};
    stateD.gpiS0 = generalPurposeInput;
    stateD.gpiS1 = stateQ.gpiS0;
    // Only synced levels reach the request logic
    route = gpi_route(stateQ.gpiFunc[3:0], stateQ.gpiS1[0])
      | gpi_route(stateQ.gpiFunc[7:4], stateQ.gpiS1[1]);
    globalReq = stateQ.enSync[1] | stateQ.ctrl[rss_pkg::GLOBAL_BIT] | route[0];
    // Master 1 startup and masters 3, 4 shutdown are immediate here
    upCode[0] = 5'h00; // [RULE3]
    upCode[1] = stateQ.upA[4:0]; // [RULE3]
    upCode[2] = stateQ.upB[4:0]; // [RULE4]
    upCode[3] = stateQ.upC[4:0]; // [RULE4]
    dnCode[0] = stateQ.dnA[4:0]; // [RULE5]
    dnCode[1] = stateQ.dnB[4:0]; // [RULE5]
    dnCode[2] = 5'h00;
    dnCode[3] = 5'h00;

    //==============================================================
    // Register writes, data phase
    // Lands before the read decode below, so a read right behind sees it
    if (stateQ.wrPend) begin
      unique case (stateQ.wIdx)
        rss_pkg::IDX_CTRL: begin
          stateD.ctrl = ahbReq.hwdata[7:0] & rss_pkg::CTRL_MASK;
        end
        rss_pkg::IDX_UP_A: begin
          stateD.upA = ahbReq.hwdata[7:0] & rss_pkg::UP_A_MASK;
        end
        rss_pkg::IDX_UP_B: begin
          stateD.upB = ahbReq.hwdata[7:0] & rss_pkg::CODE_MASK;
        end
        rss_pkg::IDX_UP_C: begin
          stateD.upC = ahbReq.hwdata[7:0] & rss_pkg::CODE_MASK;
        end
        rss_pkg::IDX_DN_A: begin
          stateD.dnA = ahbReq.hwdata[7:0] & rss_pkg::CODE_MASK;
        end
        rss_pkg::IDX_DN_B: begin
          stateD.dnB = ahbReq.hwdata[7:0] & rss_pkg::CODE_MASK;
        end
        rss_pkg::IDX_GPI_FUNC: begin
          stateD.gpiFunc = ahbReq.hwdata[7:0];
        end
        default: begin
          stateD.ctrl = stateQ.ctrl; // Unmapped writes dropped
        end
      endcase
    end

    //==============================================================
    // Register reads, address phase
    // Zero wait states: data built now, shown through the data phase
    take = ahbReq.hsel & ahbReq.htrans[1] & hready;
    stateD.wrPend = take & ahbReq.hwrite;
    stateD.wIdx = ahbReq.haddr[7:2];
    stateD.rdata = 32'h00000000;
    if (take && !ahbReq.hwrite) begin
      unique case (ahbReq.haddr[7:2])
        rss_pkg::IDX_CTRL: stateD.rdata[7:0] = stateD.ctrl;
        rss_pkg::IDX_UP_A: stateD.rdata[7:0] = stateD.upA;
        rss_pkg::IDX_UP_B: stateD.rdata[7:0] = stateD.upB;
        rss_pkg::IDX_UP_C: stateD.rdata[7:0] = stateD.upC;
        rss_pkg::IDX_DN_A: stateD.rdata[7:0] = stateD.dnA;
        rss_pkg::IDX_DN_B: stateD.rdata[7:0] = stateD.dnB;
        rss_pkg::IDX_GPI_FUNC: stateD.rdata[7:0] = stateD.gpiFunc;
        rss_pkg::IDX_STATUS: stateD.rdata[7:0] = {stateQ.pend, stateQ.outOn};
        default: stateD.rdata = 32'h00000000;
      endcase
    end

    //==============================================================
    // Per-master conditions, worked out once for the engines below
    for (int m = 0; m < 4; m++) begin
      freshEdge[m] = (globalReq != stateQ.seqOn[m])
        && (!stateQ.pend[m] || (stateQ.dir[m] != globalReq));
      backOff[m] = (globalReq == stateQ.seqOn[m]);
      expired[m] = (stateQ.msLeft[m] == 6'h00);
      msTick[m] = (stateQ.cyc[m] == 16'(MsCycles - 1));
      // Unit taken at the edge; a later change leaves this wait alone
      loadMs[m] = wait_ms(globalReq ? upCode[m] : dnCode[m], stateQ.upA[rss_pkg::UNIT_BIT]);
    end

    //==============================================================
    // Per-master delay engines
    // Own prescaler per master, so every wait is exact to the cycle
    for (int m = 0; m < 4; m++) begin
      if (freshEdge[m]) begin
        // Fresh edge: restart toward the new target
        stateD.pend[m] = 1'b1; // [RULE7]
        stateD.dir[m] = globalReq;
        stateD.cyc[m] = 16'h0000;
        stateD.msLeft[m] = loadMs[m]; // [RULE2]
      end else if (backOff[m]) begin
        // Request went back before expiry: drop the pending wait
        stateD.pend[m] = 1'b0; // [RULE7]
      end else if (expired[m]) begin
        stateD.seqOn[m] = stateQ.dir[m]; // [RULE3] [RULE4] [RULE5]
        stateD.pend[m] = 1'b0;
      end else if (msTick[m]) begin
        // Millisecond tick
        stateD.cyc[m] = 16'h0000; // [RULE7]
        stateD.msLeft[m] = stateQ.msLeft[m] - 6'h01;
      end else begin
        stateD.cyc[m] = stateQ.cyc[m] + 16'h0001;
      end
    end

    //==============================================================
    // Output enables
    // One flop behind the engines, so the pins never see a glitch
    for (int m = 0; m < 4; m++) begin
      stateD.outOn[m] = stateQ.seqOn[m] | stateQ.ctrl[m] | route[m + 1]; // [RULE6]
    end

    //==============================================================
    // Synchronous reset overrides everything above
    if (srst) begin
      stateD = '0;
      stateD.gpiFunc = rss_pkg::GPI_FUNC_RESET;
      stateD.upA = rss_pkg::CFG_RESET;
    end
  end

  //==============================================================
  // Registers
  always_ff @(posedge clock) begin
    stateQ <= stateD;
  end

  //==============================================================
  // Bus response and outputs
  // Always ready, always OKAY
  assign ahbRsp.hrdata = stateQ.rdata;
  assign ahbRsp.hreadyout = 1'b1;
  assign ahbRsp.hresp = 1'b0;
  assign masterOutputOn = stateQ.outOn;
endmodule : rss_sequencer
`default_nettype wire

// ---- inc/rss_pkg.sv ----
//==============================================================
// Behaviour
// [RULE1] One step bit picks 1 ms or 2 ms
// [RULE2] Delay equals code times unit, zero immediate
// [RULE3] Master 2 starts after its startup delay
// [RULE4] Masters 3 and 4 have own startup delays
// [RULE5] Masters 1 and 2 have own shutdown delays
// [RULE6] Output enable ORs software bit and input
// [RULE7] Per-master counter, new edge restarts it
`default_nettype none
package rss_pkg;
  //==============================================================
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h06;
  localparam logic [5:0] IDX_UP_A = 6'h07;
  localparam logic [5:0] IDX_UP_B = 6'h08;
  localparam logic [5:0] IDX_UP_C = 6'h09;
  localparam logic [5:0] IDX_DN_A = 6'h0a;
  localparam logic [5:0] IDX_DN_B = 6'h0b;
  localparam logic [5:0] IDX_GPI_FUNC = 6'h0f;
  localparam logic [5:0] IDX_STATUS = 6'h11;
  // Field positions and masks
  localparam int UNIT_BIT = 7;
  localparam int GLOBAL_BIT = 4;
  localparam logic [7:0] CODE_MASK = 8'h1f;
  localparam logic [7:0] UP_A_MASK = 8'h9f;
  localparam logic [7:0] CTRL_MASK = 8'h1f;
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] GPI_FUNC_RESET = 8'h43;
  // Input function codes: 0 global, 1..4 masters 1..4
  localparam logic [3:0] FUNC_GLOBAL = 4'h0;
  localparam logic [3:0] FUNC_LAST_MASTER = 4'h4;
  // Timing
  localparam int UNIT_SHORT_MS = 1;
  localparam int UNIT_LONG_MS = 2;
  localparam int MS_TIME_NS = 1000000;
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int MS_CYCLES = MS_TIME_NS / CLOCK_PERIOD_NS;
  //==============================================================
  // Bus carriers
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } rss_ahb_req_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } rss_ahb_rsp_t;
endpackage : rss_pkg
`default_nettype wire

// ---- test/rss_sequencer_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module rss_sequencer_bench;
  logic clock = 0, srst = 1, enablePin = 0, unit;
  logic [1:0] generalPurposeInput = 2'h0;
  logic [3:0] masterOutputOn;
  logic [31:0] r;
  logic [4:0] up[4], dn[4];
  rss_pkg::rss_ahb_req_t req = '0;
  rss_pkg::rss_ahb_rsp_t rsp;
  int mismatches = 0, check_count = 0, t[4];
  // 25 ns clock
  always #12.5 clock = ~clock;
  // Small ms count keeps delays short
  rss_sequencer #(.MsCycles(4)) dut (.clock(clock), .srst(srst), .ahbReq(req),
    .hready(rsp.hreadyout), .ahbRsp(rsp), .enablePin(enablePin),
    .generalPurposeInput(generalPurposeInput), .masterOutputOn(masterOutputOn));
  //==========
  // Helpers
  function automatic logic [31:0] span(input logic [4:0] c);
    return 32'(c) * (unit ? 32'h8 : 32'h4);
  endfunction : span
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // Sampled mid-cycle so edge updates have landed
  task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [31:0] q);
    logic rdy;
    @(posedge clock);
    req <= '{1'b1, {24'h0, i, 2'b00}, 2'b10, w, 3'h2, req.hwdata};
    do begin @(negedge clock); rdy = rsp.hreadyout; @(posedge clock); end while (!rdy);
    req <= '{1'b0, req.haddr, 2'b00, 1'b0, 3'h2, {24'h0, d}};
    do begin @(negedge clock); rdy = rsp.hreadyout; q = rsp.hrdata; @(posedge clock); end
    while (!rdy);
  endtask : xfer
  // Records the cycle each output reaches lvl
  task automatic measure(input logic lvl);
    t = '{-1, -1, -1, -1};
    @(posedge clock);
    enablePin <= lvl;
    for (int n = 0; n < 700; n++) begin
      @(negedge clock);
      for (int b = 0; b < 4; b++) if (masterOutputOn[b] === lvl && t[b] < 0) t[b] = n;
    end
  endtask : measure
  //==========
  // Sequence
  initial begin
    void'($urandom(81));
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    xfer(0, rss_pkg::IDX_GPI_FUNC, 8'h0, r); chk(r, 32'h43);
    xfer(1, 6'h3e, 8'hff, r);
    xfer(0, 6'h3e, 8'h0, r); chk(r, 32'h0);
    xfer(1, rss_pkg::IDX_GPI_FUNC, 8'hff, r);
    for (int k = 0; k < 2; k++) begin
      unit = k[0];
      up = '{5'h0, k ? 5'h1f : 5'($urandom), 5'($urandom), 5'($urandom)};
      dn = '{5'($urandom), 5'($urandom), 5'h0, 5'h0};
      xfer(1, rss_pkg::IDX_UP_A, {unit, 2'b11, up[1]}, r);
      xfer(0, rss_pkg::IDX_UP_A, 8'h0, r); chk(r, {24'h0, unit, 2'b00, up[1]});
      xfer(1, rss_pkg::IDX_UP_B, {3'h7, up[2]}, r);
      xfer(1, rss_pkg::IDX_UP_C, {3'h0, up[3]}, r);
      xfer(1, rss_pkg::IDX_DN_A, {3'h0, dn[0]}, r);
      xfer(1, rss_pkg::IDX_DN_B, {3'h0, dn[1]}, r);
      measure(1);
      for (int b = 1; b < 4; b++) chk(32'(t[b] - t[0]), span(up[b]));
      measure(0);
      for (int b = 0; b < 2; b++) chk(32'(t[b] - t[3]), span(dn[b]));
    end
    xfer(1, rss_pkg::IDX_CTRL, 8'h04, r);
    repeat (4) @(negedge clock);
    chk(masterOutputOn, 4'h4);
    xfer(1, rss_pkg::IDX_GPI_FUNC, 8'hf1, r);
    generalPurposeInput <= 2'h1;
    repeat (6) @(negedge clock);
    chk(masterOutputOn, 4'h5);
    xfer(0, rss_pkg::IDX_STATUS, 8'h0, r); chk(r, 32'h05);
    // Global turn-on from software, handed over to an input, then dropped
    xfer(1, rss_pkg::IDX_CTRL, 8'h10, r);
    repeat (300) @(negedge clock);
    chk(masterOutputOn, 4'hf);
    xfer(1, rss_pkg::IDX_GPI_FUNC, 8'hf0, r);
    xfer(1, rss_pkg::IDX_CTRL, 8'h00, r);
    repeat (8) @(negedge clock);
    chk(masterOutputOn, 4'hf);
    xfer(1, rss_pkg::IDX_GPI_FUNC, 8'hff, r);
    repeat (300) @(negedge clock);
    chk(masterOutputOn, 4'h0);
    conclude();
  end
  // Hang guard
  initial begin
    #500000;
    mismatches++;
    conclude();
  end
endmodule : rss_sequencer_bench
`default_nettype wire

// ---- test/rss_sequencer_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module rss_sequencer_sva #(parameter int MsCycles = rss_pkg::MS_CYCLES) (
  input wire logic clock,
  input wire logic srst,
  input wire rss_pkg::rss_ahb_req_t ahbReq,
  input wire logic hready,
  input wire rss_pkg::rss_ahb_rsp_t ahbRsp,
  input wire logic enablePin,
  input wire logic [1:0] generalPurposeInput,
  input wire logic [3:0] masterOutputOn
);
  //==========
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_reset_clear: assert property (disable iff (1'b0) srst |=> masterOutputOn == 4'h0)
    else $error("reset left outputs on");
  a_rise_lag: assert property ($rose(enablePin) |=> $stable(masterOutputOn))
    else $error("output moved before sync");
  a_fall_lag: assert property ($fell(enablePin) |=> $stable(masterOutputOn))
    else $error("output moved before sync");
  a_input_lag: assert property ($changed(generalPurposeInput) |=> $stable(masterOutputOn))
    else $error("output moved before sync");
  a_m2_after_m1: assert property ($rose(masterOutputOn[1]) |-> masterOutputOn[0])
    else $error("master 2 before master 1");
  a_m34_down_first: assert property ($fell(masterOutputOn[0]) |-> !masterOutputOn[3:2])
    else $error("master 1 off before 3 and 4");
  a_read_idle: assert property (!$past(ahbReq.hsel && ahbReq.htrans[1] && hready)
    |-> ahbRsp.hrdata == 32'h0) else $error("read data outside data phase");
  a_bus_okay: assert property (ahbRsp.hreadyout && !ahbRsp.hresp)
    else $error("bad bus response");
  // Main scenarios reached
  cover property ($rose(masterOutputOn[3]));
  cover property ($fell(masterOutputOn[1]));
  cover property (ahbReq.hwrite && ahbReq.htrans[1]);
endmodule : rss_sequencer_sva
bind rss_sequencer rss_sequencer_sva #(.MsCycles(MsCycles)) u_sva (.clock(clock), .srst(srst),
  .ahbReq(ahbReq), .hready(hready), .ahbRsp(ahbRsp), .enablePin(enablePin),
  .generalPurposeInput(generalPurposeInput), .masterOutputOn(masterOutputOn));
`default_nettype wire
